// File: via_pkg.sv
// Purpose: Shared constants for the vectored interrupt acknowledge block.
// Assumes: Eight maskable sources, 8-bit registers on a plain register port.
// Notes:   Source 0 ranks highest in the fixed default order.
package via_pkg;
  localparam int             NUM_SRC   = 8;
  localparam int             SRC_W     = 3;
  localparam int             DATA_W    = 8;
  localparam int             ADDR_W    = 4;
  localparam int             PC_W      = 16;

  // Register offsets on the register port.
  localparam logic [3:0]     ADR_STATUS = 4'h0;
  localparam logic [3:0]     ADR_REQ    = 4'h1;
  localparam logic [3:0]     ADR_MASK   = 4'h2;
  localparam logic [3:0]     ADR_LEVEL  = 4'h3;
  localparam logic [3:0]     ADR_INFO   = 4'h4;

  // Status word layout and reset values.
  localparam int             SW_IE_BIT  = 7;
  localparam int             SW_ISP_BIT = 1;
  localparam logic [7:0]     SW_RST     = 8'h02;
  localparam logic [7:0]     MASK_RST   = 8'hff;
  localparam logic [7:0]     LEVEL_RST  = 8'hff;
  localparam logic [7:0]     REQ_RST    = 8'h00;

  // Info register layout.
  localparam int             INFO_BUSY_BIT  = 7;
  localparam int             INFO_TRAP_BIT  = 6;
  localparam int             INFO_HOLD_BIT  = 5;

  // Vector addresses.
  localparam logic [15:0]    TRAP_VEC   = 16'h003e;
  localparam logic [15:0]    VEC_BASE   = 16'h0004;

  // Level bit value that marks a high-priority source.
  localparam logic           LVL_HIGH   = 1'b0;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_PUSH_SW = 2'b01,
    ST_PUSH_PC = 2'b11,
    ST_LOAD    = 2'b10
  } via_state_t;
endpackage

// File: via_ack.sv
// Purpose: Decides when a maskable request or software trap is taken, arbitrates,
//          and steps the sequencer through status, counter and vector handling.
// Assumes: The sequencer signals instruction boundaries and special operations
//          with one-cycle pulses; register port data is taken as synchronous.
// Notes:   Stacking itself is done by the sequencer on the push strobes.
`timescale 1ns/1ps

module via_ack
  import via_pkg::*;
(
  input  wire logic                       core_clk,
  input  wire logic                       sys_rst,
  input  wire logic [via_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [via_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [via_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic [via_pkg::NUM_SRC-1:0] src_req_set,
  input  wire logic                       instr_done,
  input  wire logic                       instr_hold,
  input  wire logic                       div_busy,
  input  wire logic                       unmask_all_op,
  input  wire logic                       mask_all_op,
  input  wire logic                       soft_trap_op,
  input  wire logic                       vectored_return_op,
  input  wire logic                       trap_return_op,
  input  wire logic [via_pkg::DATA_W-1:0] pop_status,
  output logic                            push_status_stb,
  output logic      [via_pkg::DATA_W-1:0] push_status_data,
  output logic                            push_pc_stb,
  output logic                            vector_load_stb,
  output logic      [via_pkg::PC_W-1:0]   vector_addr,
  output logic      [via_pkg::SRC_W-1:0]  ack_src_id,
  output logic                            ack_is_trap,
  output logic                            svc_busy,
  output logic      [via_pkg::DATA_W-1:0] status_word
);
  import via_pkg::*;

  via_state_t              state_ff;
  via_state_t              nxt_state;
  logic [DATA_W-1:0]       status_word_ff;
  logic [NUM_SRC-1:0]      req_ff;
  logic [NUM_SRC-1:0]      mask_ff;
  logic [NUM_SRC-1:0]      level_ff;
  logic [NUM_SRC-1:0]      elig_q_ff;
  logic                    hold_pend_ff;
  logic                    ret_pend_ff;
  logic [DATA_W-1:0]       push_sw_ff;
  logic [PC_W-1:0]         vector_ff;
  logic [SRC_W-1:0]        src_id_ff;
  logic                    trap_ff;
  logic [DATA_W-1:0]       rdata_ff;

  logic                    ie;
  logic                    in_service_level_flag;
  logic [NUM_SRC-1:0]      qualified;
  logic [NUM_SRC-1:0]      elig;
  logic [NUM_SRC-1:0]      hi_vec;
  logic [NUM_SRC-1:0]      lo_vec;
  logic                    hi_any;
  logic                    lo_any;
  logic [SRC_W-1:0]        hi_idx;
  logic [SRC_W-1:0]        lo_idx;
  logic [SRC_W-1:0]        win_idx;
  logic                    win_any;
  logic                    hold_wr;
  logic                    hold_op;
  logic                    hold_now;
  logic                    boundary_ok;
  logic                    take_mask;
  logic                    take_trap;
  logic                    take_any;
  logic [NUM_SRC-1:0]      take_onehot;
  logic                    wr_status;
  logic                    wr_req;
  logic                    wr_mask;
  logic                    wr_level;

  assign wr_status = reg_wr && (reg_addr == ADR_STATUS);
  assign wr_req    = reg_wr && (reg_addr == ADR_REQ);
  assign wr_mask   = reg_wr && (reg_addr == ADR_MASK);
  assign wr_level  = reg_wr && (reg_addr == ADR_LEVEL);

  assign ie  = status_word_ff[SW_IE_BIT];
  assign in_service_level_flag = status_word_ff[SW_ISP_BIT];

  // A source qualifies on its own flags; enable and level gate it after that.
  assign qualified = req_ff & ~mask_ff;

  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      // Level 0 in service admits only high sources; level 1 admits all.
      elig[i] = qualified[i] && ie && ((level_ff[i] == LVL_HIGH) || in_service_level_flag);
    end
  end

  // Low-priority sources must stay eligible one clock longer than high ones.
  assign hi_vec = elig & ~level_ff;
  assign lo_vec = elig & elig_q_ff & level_ff;

  via_first_set #(
    .N (NUM_SRC),
    .W (SRC_W)
  ) u_hi_pick (
    .vec   (hi_vec),
    .found (hi_any),
    .idx   (hi_idx)
  );

  via_first_set #(
    .N (NUM_SRC),
    .W (SRC_W)
  ) u_lo_pick (
    .vec   (lo_vec),
    .found (lo_any),
    .idx   (lo_idx)
  );

  assign win_any = hi_any || lo_any;
  assign win_idx = hi_any ? hi_idx : lo_idx;

  // The instruction finishing now is a hold instruction, or touched flags.
  assign hold_wr  = wr_status || wr_req || wr_mask || wr_level;
  assign hold_op  = unmask_all_op || mask_all_op
                  || vectored_return_op || trap_return_op;
  assign hold_now = instr_hold || hold_pend_ff || ret_pend_ff
                  || hold_wr || hold_op;

  // The trap does not count as a hold; a divide in flight stretches the wait.
  assign boundary_ok = instr_done && !hold_now && !div_busy;

  assign take_trap = soft_trap_op && (state_ff == ST_IDLE);
  assign take_mask = boundary_ok && win_any && (state_ff == ST_IDLE)
                   && !take_trap;
  assign take_any  = take_trap || take_mask;

  always_comb begin
    take_onehot = '0;
    if (take_mask) begin
      take_onehot[win_idx] = 1'b1;
    end
  end

  // Eligibility history for the extra low-priority clock.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      elig_q_ff <= '0;
    end else begin
      elig_q_ff <= elig;
    end
  end

  // Register writes that arrive mid-instruction block the boundary that ends it.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_pend_ff <= 1'b0;
    end else if (instr_done) begin
      hold_pend_ff <= 1'b0;
    end else if (hold_wr) begin
      hold_pend_ff <= 1'b1;
    end
  end

  // Enable ops and returns inside an instruction block the boundary that ends it.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ret_pend_ff <= 1'b0;
    end else if (instr_done) begin
      ret_pend_ff <= 1'b0;
    end else if (hold_op) begin
      ret_pend_ff <= 1'b1;
    end
  end

  // Request flags: a new request wins over a clear in the same cycle.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_ff <= REQ_RST;
    end else if (wr_req) begin
      req_ff <= reg_wdata | src_req_set;
    end else begin
      req_ff <= (req_ff & ~take_onehot) | src_req_set;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_ff <= MASK_RST;
    end else if (wr_mask) begin
      mask_ff <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      level_ff <= LEVEL_RST;
    end else if (wr_level) begin
      level_ff <= reg_wdata;
    end
  end

  // Status word: take beats return, return beats enable ops, those beat writes.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_word_ff <= SW_RST;
    end else if (take_trap) begin
      status_word_ff[SW_IE_BIT] <= 1'b0;
    end else if (take_mask) begin
      status_word_ff[SW_IE_BIT]  <= 1'b0;
      status_word_ff[SW_ISP_BIT] <= level_ff[win_idx];
    end else if (vectored_return_op || trap_return_op) begin
      status_word_ff <= pop_status;
    end else if (unmask_all_op) begin
      status_word_ff[SW_IE_BIT] <= 1'b1;
    end else if (mask_all_op) begin
      status_word_ff[SW_IE_BIT] <= 1'b0;
    end else if (wr_status) begin
      status_word_ff <= reg_wdata;
    end
  end

  // Capture what the sequencer needs at the moment of the take.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      push_sw_ff <= '0;
      vector_ff  <= '0;
      src_id_ff  <= '0;
      trap_ff    <= 1'b0;
    end else if (take_trap) begin
      push_sw_ff <= status_word_ff;
      vector_ff  <= TRAP_VEC;
      trap_ff    <= 1'b1;
    end else if (take_mask) begin
      push_sw_ff <= status_word_ff;
      vector_ff  <= VEC_BASE + PC_W'({win_idx, 1'b0});
      src_id_ff  <= win_idx;
      trap_ff    <= 1'b0;
    end
  end

  // Sequence: push status, push counter, load vector.
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (take_any) begin
          nxt_state = ST_PUSH_SW;
        end
      end
      ST_PUSH_SW: begin
        nxt_state = ST_PUSH_PC;
      end
      ST_PUSH_PC: begin
        nxt_state = ST_LOAD;
      end
      ST_LOAD: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign push_status_stb  = (state_ff == ST_PUSH_SW);
  assign push_pc_stb      = (state_ff == ST_PUSH_PC);
  assign vector_load_stb  = (state_ff == ST_LOAD);
  assign push_status_data = push_sw_ff;
  assign vector_addr      = vector_ff;
  assign ack_src_id       = src_id_ff;
  assign ack_is_trap      = trap_ff;
  assign svc_busy         = (state_ff != ST_IDLE);
  assign status_word      = status_word_ff;

  // Read data stand in the cycle after the strobe only.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADR_STATUS: rdata_ff <= status_word_ff;
        ADR_REQ:    rdata_ff <= req_ff;
        ADR_MASK:   rdata_ff <= mask_ff;
        ADR_LEVEL:  rdata_ff <= level_ff;
        ADR_INFO: begin
          rdata_ff                <= '0;
          rdata_ff[INFO_BUSY_BIT] <= svc_busy;
          rdata_ff[INFO_TRAP_BIT] <= trap_ff;
          rdata_ff[INFO_HOLD_BIT] <= hold_pend_ff || ret_pend_ff;
          rdata_ff[SRC_W-1:0]     <= src_id_ff;
        end
        default:    rdata_ff <= '0;
      endcase
    end else begin
      rdata_ff <= '0;
    end
  end

  assign reg_rdata = rdata_ff;
endmodule

// Finds the lowest set bit, so source 0 gets the top default rank.
module via_first_set
  import via_pkg::*;
#(
  parameter int N = NUM_SRC,
  parameter int W = SRC_W
)
(
  input  wire logic [N-1:0] vec,
  output logic              found,
  output logic [W-1:0]      idx
);
  import via_pkg::*;

  always_comb begin
    found = 1'b0;
    idx   = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (vec[i]) begin
        found = 1'b1;
        idx   = W'(i);
      end
    end
  end
endmodule

// File: via_ack_assertions.sv
// Purpose: Port-level timing checks for the acknowledge block.
// Assumes: One clock domain; reset is asynchronous and active high.
// Notes:   Bound to every instance of the block.
`timescale 1ns/1ps
module via_ack_assertions
  import via_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        instr_done,
  input wire logic        instr_hold,
  input wire logic        soft_trap_op,
  input wire logic        vectored_return_op,
  input wire logic [7:0]  pop_status,
  input wire logic        push_status_stb,
  input wire logic [7:0]  push_status_data,
  input wire logic        push_pc_stb,
  input wire logic        vector_load_stb,
  input wire logic [15:0] vector_addr,
  input wire logic [2:0]  ack_src_id,
  input wire logic        ack_is_trap,
  input wire logic        svc_busy,
  input wire logic [7:0]  status_word
);
  default clocking dcb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  sequence tail_s;
    push_pc_stb ##1 vector_load_stb ##1 !svc_busy;
  endsequence
  step_order_a: assert property (push_status_stb |=> tail_s)
    else $error("take steps out of order");
  enable_clear_a: assert property (push_status_stb |-> !status_word[SW_IE_BIT])
    else $error("enable not cleared on take");
  trap_vector_a: assert property (push_status_stb && ack_is_trap |-> vector_addr == TRAP_VEC)
    else $error("trap vector wrong");
  source_vector_a: assert property (push_status_stb && !ack_is_trap
    |-> vector_addr == VEC_BASE + {ack_src_id, 1'b0}) else $error("source vector wrong");
  pushed_status_a: assert property (push_status_stb |-> push_status_data == $past(status_word))
    else $error("pushed status wrong");
  disabled_refuse_a: assert property (instr_done && !status_word[SW_IE_BIT] && !soft_trap_op
    |=> !push_status_stb) else $error("take while disabled");
  trap_always_a: assert property (soft_trap_op && !svc_busy |=> push_status_stb && ack_is_trap)
    else $error("trap not taken");
  hold_defer_a: assert property (instr_done && (instr_hold || vectored_return_op)
    && !soft_trap_op |=> !push_status_stb) else $error("take after hold");
  return_restore_a: assert property (vectored_return_op && !soft_trap_op && !svc_busy
    |=> status_word == $past(pop_status)) else $error("status not restored");
  busy_span_a: assert property ($rose(svc_busy) |-> svc_busy [*3] ##1 !svc_busy)
    else $error("busy span wrong");
  reset_value_a: assert property ($fell(sys_rst) |-> status_word == SW_RST)
    else $error("status reset value wrong");
endmodule

bind via_ack via_ack_assertions u_chk (.core_clk(core_clk), .sys_rst(sys_rst),
  .instr_done(instr_done), .instr_hold(instr_hold), .soft_trap_op(soft_trap_op),
  .vectored_return_op(vectored_return_op), .pop_status(pop_status),
  .push_status_stb(push_status_stb), .push_status_data(push_status_data),
  .push_pc_stb(push_pc_stb), .vector_load_stb(vector_load_stb),
  .vector_addr(vector_addr), .ack_src_id(ack_src_id), .ack_is_trap(ack_is_trap),
  .svc_busy(svc_busy), .status_word(status_word));

// File: via_seq_model.sv
// Purpose: Sequencer stand-in with instruction boundaries and a status stack.
// Assumes: Return pulses arrive from the bench through pop_req.
// Notes:   Instruction length, hold instructions and divide stalls are random.
`timescale 1ns/1ps
module via_seq_model (
  input  wire logic       core_clk,
  input  wire logic       push_status_stb,
  input  wire logic [7:0] push_status_data,
  input  wire logic       pop_req,
  output logic            instr_done = 1'b0,
  output logic            instr_hold = 1'b0,
  output logic            div_busy = 1'b0,
  output logic [7:0]      pop_status
);
  logic [7:0] stk [16];
  logic [3:0] sp_ff  = 4'h0;
  logic [1:0] len_ff = 2'h0;
  assign pop_status = stk[sp_ff - 4'h1];
  always @(posedge core_clk) begin
    if (push_status_stb) begin
      stk[sp_ff] <= push_status_data;
      sp_ff <= sp_ff + 4'h1;
    end else if (pop_req) begin
      sp_ff <= sp_ff - 4'h1;
    end
    instr_done <= (len_ff == 2'h0);
    instr_hold <= (len_ff == 2'h0) && ($urandom_range(3) == 0);
    len_ff <= (len_ff == 2'h0) ? 2'($urandom_range(2)) : len_ff - 2'h1;
    div_busy <= ($urandom_range(15) == 0);
  end
endmodule

// File: test_via_ack.sv
// Purpose: Self-checking bench for the acknowledge block.
// Assumes: The sequencer model paces instruction boundaries.
// Notes:   Expected takes are queued in the order they must appear.
`timescale 1ns/1ps
module test_via_ack;
  import via_pkg::*;
  localparam logic [4:0] UNM = 5'h01, MSK = 5'h02, TRP = 5'h04, VRT = 5'h08, TRT = 5'h10;
  logic        core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00, src_req_set = 8'h00, lvl, req;
  logic [4:0]  ops = 5'h00;
  logic [7:0]  reg_rdata, pop_status, push_status_data, status_word;
  logic        instr_done, instr_hold, div_busy, push_status_stb, push_pc_stb;
  logic        vector_load_stb, ack_is_trap, svc_busy;
  logic [15:0] vector_addr;
  logic [2:0]  ack_src_id;
  logic [15:0] exp_v[$];
  logic [15:0] ev;
  logic [7:0]  exp_r[$];
  int          fails = 0, checks_done = 0, takes = 0, tk_exp = 0, cyc = 0;

  initial forever #2.5 core_clk = ~core_clk;

  via_ack dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .src_req_set(src_req_set), .instr_done(instr_done), .instr_hold(instr_hold),
    .div_busy(div_busy), .unmask_all_op(ops[0]), .mask_all_op(ops[1]),
    .soft_trap_op(ops[2]), .vectored_return_op(ops[3]), .trap_return_op(ops[4]),
    .pop_status(pop_status), .push_status_stb(push_status_stb),
    .push_status_data(push_status_data), .push_pc_stb(push_pc_stb),
    .vector_load_stb(vector_load_stb), .vector_addr(vector_addr),
    .ack_src_id(ack_src_id), .ack_is_trap(ack_is_trap), .svc_busy(svc_busy),
    .status_word(status_word));

  via_seq_model seq (.core_clk(core_clk), .push_status_stb(push_status_stb),
    .push_status_data(push_status_data), .pop_req(ops[3] | ops[4]),
    .instr_done(instr_done), .instr_hold(instr_hold), .div_busy(div_busy),
    .pop_status(pop_status));

  task automatic summarize();
    if (fails == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp_v(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_r(input logic [7:0] got, input logic [7:0] exp);
    cmp_v({8'h00, got}, {8'h00, exp});
  endtask

  // Results are compared in the cycle where they stand.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
    if (rd_d)
      cmp_r(reg_rdata, exp_r.pop_front());
    rd_d <= reg_rd;
    if (push_status_stb) begin
      takes++;
      ev = exp_v.pop_front();
      cmp_v(vector_addr, ev);
      if (ev != TRAP_VEC)
        cmp_r({5'h00, ack_src_id}, 8'((ev - VEC_BASE) >> 1));
      cmp_r({7'h00, ack_is_trap}, {7'h00, ev == TRAP_VEC});
    end
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_r.push_back(e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask

  task automatic op(input logic [4:0] k, input logic [7:0] r);
    @(posedge core_clk);
    ops <= k;
    src_req_set <= r;
    @(posedge core_clk);
    ops <= 5'h00;
    src_req_set <= 8'h00;
  endtask

  task automatic expect_take(input logic [15:0] v);
    exp_v.push_back(v);
    tk_exp++;
  endtask

  task automatic wait_take();
    for (int i = 0; i < 300 && takes < tk_exp; i++) @(posedge core_clk);
    repeat (6) @(posedge core_clk);
  endtask

  initial begin
    void'($urandom(32'h045f));
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(ADR_STATUS, SW_RST);
    rd(ADR_LEVEL, LEVEL_RST);
    rd(4'hf, 8'h00);
    wr(ADR_MASK, 8'h00);
    for (int it = 0; it < 6; it++) begin
      lvl = 8'($urandom);
      req = 8'($urandom) | 8'h01;
      wr(ADR_LEVEL, lvl);
      op(5'h00, req);
      rd(ADR_REQ, req);
      for (int p = 0; p < 2; p++)
        for (int i = 0; i < 8; i++)
          if (req[i] && lvl[i] == p[0]) expect_take(VEC_BASE + 16'(2 * i));
      op(UNM, 8'h00);
      repeat ($countones(req)) begin
        wait_take();
        op(VRT, 8'h00);
      end
      op(MSK, 8'h00);
      rd(ADR_STATUS, 8'h02);
    end
    wr(ADR_LEVEL, 8'hfe);
    expect_take(VEC_BASE + 16'h0002);
    op(UNM, 8'h02);
    wait_take();
    expect_take(VEC_BASE);
    op(UNM, 8'h01);
    wait_take();
    expect_take(TRAP_VEC);
    op(UNM, 8'h04);
    repeat (20) @(posedge core_clk);
    op(TRP, 8'h00);
    wait_take();
    op(TRT, 8'h00);
    repeat (20) @(posedge core_clk);
    expect_take(VEC_BASE + 16'h0004);
    op(VRT, 8'h00);
    wait_take();
    op(VRT, 8'h00);
    repeat (6) @(posedge core_clk);
    op(VRT, 8'h00);
    rd(ADR_STATUS, 8'h82);
    repeat (4) @(posedge core_clk);
    if (exp_v.size() != 0)
      fails++;
    summarize();
  end
endmodule
